/* rtl/lmd_defines.svh */
// Opcode, field and timing constants for the logic and move decoder
`ifndef LMD_DEFINES_SVH
`define LMD_DEFINES_SVH
// ----------------------------------------
// Opcode high nibbles of register groups
// ----------------------------------------
`define LMD_HI_AND      4'h5
`define LMD_HI_OR       4'h4
`define LMD_HI_XOR      4'h6
`define LMD_HI_MOVA     4'hE
`define LMD_HI_MOVR_A   4'hF
`define LMD_HI_MOVR_DIR 4'hA
`define LMD_HI_MOVR_IMM 4'h7
`define LMD_HI_MOVD_R   4'h8
`define LMD_HI_XCH      4'hC
// ----------------------------------------
// Low nibbles of the logic groups
// ----------------------------------------
`define LMD_LO_DIR_A    4'h2
`define LMD_LO_DIR_IMM  4'h3
`define LMD_LO_A_IMM    4'h4
`define LMD_LO_A_DIR    4'h5
`define LMD_LO_IND      3'h3
// ----------------------------------------
// Single opcodes
// ----------------------------------------
`define LMD_OPC_CLR     8'hE4
`define LMD_OPC_CPL     8'hF4
`define LMD_OPC_SWAP    8'hC4
`define LMD_OPC_RL      8'h23
`define LMD_OPC_RLC     8'h33
`define LMD_OPC_RR      8'h03
`define LMD_OPC_RRC     8'h13
`define LMD_OPC_MOVA_D  8'hE5
`define LMD_OPC_MOVA_I  8'h74
`define LMD_OPC_MOVD_A  8'hF5
`define LMD_OPC_MOVD_D  8'h85
`define LMD_OPC_MOVD_I  8'h75
`define LMD_OPC_DATA_POINTER    8'h90
`define LMD_OPC_TBL_DP  8'h93
`define LMD_OPC_TBL_PC  8'h83
`define LMD_OPC_XRD_DP  8'hE0
`define LMD_OPC_XWR_DP  8'hF0
`define LMD_OPC_PUSH    8'hC0
`define LMD_OPC_POP     8'hD0
`define LMD_OPC_XCH_D   8'hC5
// ----------------------------------------
// Even member of indirect opcode pairs
// ----------------------------------------
`define LMD_PR_MOVA_IND 8'hE6
`define LMD_PR_MOVD_IND 8'h86
`define LMD_PR_MOVI_A   8'hF6
`define LMD_PR_MOVI_D   8'hA6
`define LMD_PR_MOVI_IMM 8'h76
`define LMD_PR_XRD_RI   8'hE2
`define LMD_PR_XWR_RI   8'hF2
`define LMD_PR_XCH_IND  8'hC6
`define LMD_PR_LOW_NIBBLE_EXCHANGE_OP     8'hD6
// ----------------------------------------
// Lengths, cycles and timing
// ----------------------------------------
`define LMD_LEN1        2'h1
`define LMD_LEN2        2'h2
`define LMD_LEN3        2'h3
`define LMD_CYC1        2'h1
`define LMD_CYC2        2'h2
`define LMD_MCYCLE_CLKS 12
`define LMD_ACC_SFR     8'hE0
`endif

/* rtl/lmd_pkg.sv */
// Types shared by the logic and move decoder
package lmd_pkg;
  typedef enum logic [4:0] {
    OP_OTHER = 5'h00, OP_AND = 5'h01, OP_OR = 5'h02, OP_XOR = 5'h03,
    OP_CLEAR = 5'h04, OP_INVERT = 5'h05, OP_SWAP = 5'h06, OP_ROT_L = 5'h07,
    OP_ROT_LC = 5'h08, OP_ROT_R = 5'h09, OP_ROT_RC = 5'h0A, OP_MOVE = 5'h0B,
    OP_DATA_POINTER_LOAD = 5'h0C, OP_CODE_TABLE = 5'h0D, OP_EXT_READ = 5'h0E,
    OP_EXT_WRITE = 5'h0F, OP_PUSH = 5'h10, OP_POP = 5'h11, OP_XCH = 5'h12,
    OP_LOW_NIBBLE_EXCHANGE_OP = 5'h13
  } lmd_op_e;
  typedef enum logic [2:0] {
    M_NONE = 3'h0, M_ACC = 3'h1, M_REG = 3'h2, M_DIR = 3'h3,
    M_IND = 3'h4, M_IMM = 3'h5, M_DATA_POINTER = 3'h6, M_CODE = 3'h7
  } lmd_mode_e;
  typedef enum logic [1:0] {
    ST_REQ = 2'b00, ST_WAIT = 2'b01, ST_EXEC = 2'b10
  } lmd_state_e;
  typedef struct packed {
    lmd_op_e    op;
    lmd_mode_e  src;
    lmd_mode_e  dst;
    logic [1:0] len;
    logic [1:0] cyc;
    logic       known;
  } lmd_info_s;
  typedef struct packed {
    lmd_info_s  info;
    logic [7:0] opcode;
    logic [7:0] opnd1;
    logic [7:0] opnd2;
    logic [4:0] reg_addr;
  } lmd_dec_s;
endpackage

/* rtl/lmd_opcode_table.sv */
// Opcode lookup: class, operand modes, length and machine cycles
`timescale 1ns/1ps
`include "lmd_defines.svh"
module lmd_opcode_table (
  input  logic              [7:0] opcode,
  output lmd_pkg::lmd_info_s      info
);
  import lmd_pkg::*;

  function automatic lmd_info_s mk(lmd_op_e o, lmd_mode_e s, lmd_mode_e d,
                                   logic [1:0] l, logic [1:0] c);
    mk = '{op: o, src: s, dst: d, len: l, cyc: c, known: 1'b1};
  endfunction

  logic [3:0] hi;
  logic [3:0] lo;
  logic       rr;
  logic       ind;
  lmd_op_e    lg;

  assign hi  = opcode[7:4];
  assign lo  = opcode[3:0];
  assign rr  = opcode[3];
  assign ind = (opcode[3:1] == `LMD_LO_IND);
  assign lg  = (hi == `LMD_HI_AND) ? OP_AND : (hi == `LMD_HI_OR) ? OP_OR : OP_XOR;

  always_comb begin
    info = '{op: OP_OTHER, src: M_NONE, dst: M_NONE, len: `LMD_LEN1, cyc: `LMD_CYC1, known: 1'b0};
    if (hi == `LMD_HI_AND || hi == `LMD_HI_OR || hi == `LMD_HI_XOR) begin // RQ1 RQ2 RQ3
      if (rr) info = mk(lg, M_REG, M_ACC, `LMD_LEN1, `LMD_CYC1);
      else if (ind) info = mk(lg, M_IND, M_ACC, `LMD_LEN1, `LMD_CYC1);
      else if (lo == `LMD_LO_A_DIR) info = mk(lg, M_DIR, M_ACC, `LMD_LEN2, `LMD_CYC1);
      else if (lo == `LMD_LO_A_IMM) info = mk(lg, M_IMM, M_ACC, `LMD_LEN2, `LMD_CYC1);
      else if (lo == `LMD_LO_DIR_A) info = mk(lg, M_ACC, M_DIR, `LMD_LEN2, `LMD_CYC1);
      else if (lo == `LMD_LO_DIR_IMM) info = mk(lg, M_IMM, M_DIR, `LMD_LEN3, `LMD_CYC2);
    end else if (rr) begin
      case (hi)
        `LMD_HI_MOVA:     info = mk(OP_MOVE, M_REG, M_ACC, `LMD_LEN1, `LMD_CYC1); // RQ6
        `LMD_HI_MOVR_A:   info = mk(OP_MOVE, M_ACC, M_REG, `LMD_LEN1, `LMD_CYC1); // RQ8
        `LMD_HI_MOVR_DIR: info = mk(OP_MOVE, M_DIR, M_REG, `LMD_LEN2, `LMD_CYC2); // RQ8
        `LMD_HI_MOVR_IMM: info = mk(OP_MOVE, M_IMM, M_REG, `LMD_LEN2, `LMD_CYC1); // RQ8
        `LMD_HI_MOVD_R:   info = mk(OP_MOVE, M_REG, M_DIR, `LMD_LEN2, `LMD_CYC2); // RQ9
        `LMD_HI_XCH:      info = mk(OP_XCH, M_REG, M_ACC, `LMD_LEN1, `LMD_CYC1); // RQ17
        default: ;
      endcase
    end else begin
      case (opcode)
        `LMD_OPC_CLR:    info = mk(OP_CLEAR, M_NONE, M_ACC, `LMD_LEN1, `LMD_CYC1); // RQ4
        `LMD_OPC_CPL:    info = mk(OP_INVERT, M_ACC, M_ACC, `LMD_LEN1, `LMD_CYC1);
        `LMD_OPC_SWAP:   info = mk(OP_SWAP, M_ACC, M_ACC, `LMD_LEN1, `LMD_CYC1);
        `LMD_OPC_RL:     info = mk(OP_ROT_L, M_ACC, M_ACC, `LMD_LEN1, `LMD_CYC1); // RQ5
        `LMD_OPC_RLC:    info = mk(OP_ROT_LC, M_ACC, M_ACC, `LMD_LEN1, `LMD_CYC1);
        `LMD_OPC_RR:     info = mk(OP_ROT_R, M_ACC, M_ACC, `LMD_LEN1, `LMD_CYC1);
        `LMD_OPC_RRC:    info = mk(OP_ROT_RC, M_ACC, M_ACC, `LMD_LEN1, `LMD_CYC1);
        `LMD_OPC_MOVA_D: info = mk(OP_MOVE, M_DIR, M_ACC, `LMD_LEN2, `LMD_CYC1); // RQ6
        `LMD_OPC_MOVA_I: info = mk(OP_MOVE, M_IMM, M_ACC, `LMD_LEN2, `LMD_CYC1);
        `LMD_OPC_MOVD_A: info = mk(OP_MOVE, M_ACC, M_DIR, `LMD_LEN2, `LMD_CYC1);
        `LMD_OPC_MOVD_D: info = mk(OP_MOVE, M_DIR, M_DIR, `LMD_LEN3, `LMD_CYC2);
        `LMD_OPC_MOVD_I: info = mk(OP_MOVE, M_IMM, M_DIR, `LMD_LEN3, `LMD_CYC2); // RQ10
        `LMD_OPC_DATA_POINTER:   info = mk(OP_DATA_POINTER_LOAD, M_IMM, M_DATA_POINTER, `LMD_LEN3, `LMD_CYC2); // RQ12
        `LMD_OPC_TBL_DP: info = mk(OP_CODE_TABLE, M_CODE, M_ACC, `LMD_LEN1, `LMD_CYC2); // RQ13
        `LMD_OPC_TBL_PC: info = mk(OP_CODE_TABLE, M_CODE, M_ACC, `LMD_LEN1, `LMD_CYC2);
        `LMD_OPC_XRD_DP: info = mk(OP_EXT_READ, M_DATA_POINTER, M_ACC, `LMD_LEN1, `LMD_CYC2); // RQ14
        `LMD_OPC_XWR_DP: info = mk(OP_EXT_WRITE, M_ACC, M_DATA_POINTER, `LMD_LEN1, `LMD_CYC2); // RQ15
        `LMD_OPC_PUSH:   info = mk(OP_PUSH, M_DIR, M_NONE, `LMD_LEN2, `LMD_CYC2); // RQ16
        `LMD_OPC_POP:    info = mk(OP_POP, M_NONE, M_DIR, `LMD_LEN2, `LMD_CYC2);
        `LMD_OPC_XCH_D:  info = mk(OP_XCH, M_DIR, M_ACC, `LMD_LEN2, `LMD_CYC1);
        default: ;
      endcase
      case ({opcode[7:1], 1'b0})
        `LMD_PR_MOVA_IND: info = mk(OP_MOVE, M_IND, M_ACC, `LMD_LEN1, `LMD_CYC1);
        `LMD_PR_MOVD_IND: info = mk(OP_MOVE, M_IND, M_DIR, `LMD_LEN2, `LMD_CYC2);
        `LMD_PR_MOVI_A:   info = mk(OP_MOVE, M_ACC, M_IND, `LMD_LEN1, `LMD_CYC1); // RQ11 RQ20
        `LMD_PR_MOVI_D:   info = mk(OP_MOVE, M_DIR, M_IND, `LMD_LEN2, `LMD_CYC2);
        `LMD_PR_MOVI_IMM: info = mk(OP_MOVE, M_IMM, M_IND, `LMD_LEN2, `LMD_CYC1);
        `LMD_PR_XRD_RI:   info = mk(OP_EXT_READ, M_IND, M_ACC, `LMD_LEN1, `LMD_CYC2);
        `LMD_PR_XWR_RI:   info = mk(OP_EXT_WRITE, M_ACC, M_IND, `LMD_LEN1, `LMD_CYC2);
        `LMD_PR_XCH_IND:  info = mk(OP_XCH, M_IND, M_ACC, `LMD_LEN1, `LMD_CYC1);
        `LMD_PR_LOW_NIBBLE_EXCHANGE_OP:     info = mk(OP_LOW_NIBBLE_EXCHANGE_OP, M_IND, M_ACC, `LMD_LEN1, `LMD_CYC1); // RQ18
        default: ;
      endcase
    end
  end
endmodule

/* rtl/lmd_decoder.sv */
// Fetch sequencer and decoder for logic and data-move instructions
// ----------------------------------------
// How it works
// (RQ1) AND group: reg, direct, indirect, immediate, A-to-direct one cycle; imm-to-direct 3B/2C.
// (RQ2) OR group decodes the same forms at 0x4x; imm-to-direct 3B/2C.
// (RQ3) XOR group decodes the same forms at 0x6x; imm-to-direct 3B/2C.
// (RQ4) Clear, invert and nibble swap of A: one byte, one cycle.
// (RQ5) Four rotates, two through carry, each one cycle.
// (RQ6) Loads into A from reg, direct, indirect or immediate in one cycle.
// (RQ7) Software must not move the accumulator onto itself directly; flagged.
// (RQ8) Moves into a working register from A, direct or immediate.
// (RQ9) Moves into a direct byte from A, register or direct.
// (RQ10) Direct byte from indirect RAM or immediate: two cycles.
// (RQ11) Indirect RAM from A, direct or immediate.
// (RQ12) 0x90 loads the data pointer from the next two bytes.
// (RQ13) Code table reads at A plus data pointer or A plus PC.
// (RQ14) External reads into A: one byte, two cycles.
// (RQ15) External writes from A: one byte, two cycles.
// (RQ16) Push and pop of a direct byte: two bytes, two cycles.
// (RQ17) Full exchanges with A complete in one cycle.
// (RQ18) Low-nibble exchange with indirect RAM: one byte, one cycle.
// (RQ19) Low three opcode bits pick working register zero to seven.
// (RQ20) Indirect pointer is register 0 or 1 of the selected bank.
// (RQ21) Operand bytes follow the opcode; PC advances by the length.
// ----------------------------------------
`timescale 1ns/1ps
`include "lmd_defines.svh"
module lmd_decoder #(
  parameter int         MCYCLE_CLKS  = `LMD_MCYCLE_CLKS,
  parameter logic [7:0] ACC_SFR_ADDR = `LMD_ACC_SFR
) (
  input  logic                    sys_clk,
  input  logic                    rst_n,
  input  logic             [1:0]  bank_sel,
  input  logic             [7:0]  acc_value,
  input  logic                    code_ack,
  input  logic             [7:0]  code_data,
  output logic                    code_rd,
  output logic             [15:0] code_addr,
  output logic                    dec_valid,
  output lmd_pkg::lmd_dec_s       dec,
  output logic                    busy,
  output logic                    exec_done,
  output logic             [15:0] pc,
  output logic             [15:0] data_pointer,
  output logic             [15:0] table_addr,
  output logic                    misuse_flag,
  output logic                    unknown_flag
);
  import lmd_pkg::*;

  localparam int CW = $clog2(2 * MCYCLE_CLKS + 2);

  // ----------------------------------------
  // Fetch state
  // ----------------------------------------
  lmd_state_e  state;
  logic [1:0]  byte_idx;
  logic [7:0]  opc_q;
  logic [7:0]  b1_q;
  logic [7:0]  tbl_opc;
  logic [7:0]  cur_opc;
  lmd_info_s   info_now;
  logic        last;
  logic [CW-1:0] exec_cnt;
  logic [CW-1:0] exec_len;
  logic [2:0]  reg_idx;
  logic [15:0] next_pc;

  // Opcode byte is looked up as it arrives so one-byte forms need no extra cycle
  assign tbl_opc  = (byte_idx == 2'h0) ? code_data : opc_q;
  assign cur_opc  = tbl_opc;
  assign last     = (state == ST_WAIT) && code_ack && (byte_idx + 2'h1 == info_now.len);
  assign exec_len = CW'(int'(info_now.cyc) * MCYCLE_CLKS);
  assign next_pc  = pc + 16'h0001;
  // Working register from low bits; indirect pointer from bit zero
  assign reg_idx  = (info_now.src == M_IND || info_now.dst == M_IND) ? {2'h0, cur_opc[0]} : cur_opc[2:0];

  lmd_opcode_table u_table (
    .opcode (tbl_opc),
    .info   (info_now)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ST_REQ;
    end else begin
      unique case (state)
        ST_REQ: begin
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (code_ack) begin
            state <= last ? ST_EXEC : ST_REQ; // RQ21
          end
        end
        ST_EXEC: begin
          if (exec_cnt == CW'(1)) begin
            state <= ST_REQ;
          end
        end
        default: begin
          state <= ST_REQ;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Program memory requests
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      code_rd   <= 1'b0;
      code_addr <= 16'h0000;
    end else begin
      code_rd <= (state == ST_REQ);
      if (state == ST_REQ) begin
        code_addr <= pc; // RQ21
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pc <= 16'h0000;
    end else if (state == ST_WAIT && code_ack) begin
      pc <= next_pc; // RQ21
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      byte_idx <= 2'h0;
      opc_q    <= 8'h00;
      b1_q     <= 8'h00;
    end else if (state == ST_WAIT && code_ack) begin
      byte_idx <= last ? 2'h0 : byte_idx + 2'h1;
      if (byte_idx == 2'h0) begin
        opc_q <= code_data;
      end
      if (byte_idx == 2'h1) begin
        b1_q <= code_data;
      end
    end
  end

  // ----------------------------------------
  // Decode result
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dec_valid <= 1'b0;
      dec       <= '0;
    end else begin
      dec_valid <= last;
      if (last) begin
        dec.info     <= info_now; // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6 RQ8 RQ9 RQ10 RQ11 RQ14 RQ15 RQ16 RQ17 RQ18
        dec.opcode   <= cur_opc;
        dec.opnd1    <= (byte_idx == 2'h1) ? code_data : b1_q;
        dec.opnd2    <= (byte_idx == 2'h2) ? code_data : 8'h00;
        dec.reg_addr <= {bank_sel, reg_idx}; // RQ19 RQ20
      end
    end
  end

  // Operand bytes high then low, as the pointer is stored
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      data_pointer <= 16'h0000;
    end else if (last && cur_opc == `LMD_OPC_DATA_POINTER) begin
      data_pointer <= {b1_q, code_data}; // RQ12
    end
  end

  // Table base is the data pointer for 0x93 and the PC of the next instruction for 0x83
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      table_addr <= 16'h0000;
    end else if (last && cur_opc == `LMD_OPC_TBL_DP) begin
      table_addr <= data_pointer + {8'h00, acc_value}; // RQ13
    end else if (last && cur_opc == `LMD_OPC_TBL_PC) begin
      table_addr <= next_pc + {8'h00, acc_value}; // RQ13
    end
  end

  // Flagged only; the datapath still runs it since the code is at fault
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      misuse_flag  <= 1'b0;
      unknown_flag <= 1'b0;
    end else begin
      misuse_flag  <= last && cur_opc == `LMD_OPC_MOVA_D && code_data == ACC_SFR_ADDR; // RQ7
      unknown_flag <= last && !info_now.known;
    end
  end

  // ----------------------------------------
  // Machine cycle timing
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      exec_cnt  <= '0;
      busy      <= 1'b0;
      exec_done <= 1'b0;
    end else begin
      exec_done <= (state == ST_EXEC) && exec_cnt == CW'(1);
      if (last) begin
        exec_cnt <= exec_len;
        busy     <= 1'b1;
      end else if (state == ST_EXEC) begin
        exec_cnt <= exec_cnt - CW'(1);
        if (exec_cnt == CW'(1)) begin
          busy <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [CW-1:0] span;
  logic [15:0]   pc_start;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      span     <= '0;
      pc_start <= 16'h0000;
    end else begin
      if (dec_valid) begin
        span <= CW'(1);
      end else if (busy) begin
        span <= span + CW'(1);
      end
      if (state == ST_REQ && byte_idx == 2'h0) begin
        pc_start <= pc;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_exec_length: assert property (exec_done |-> span == CW'(int'(dec.info.cyc) * MCYCLE_CLKS)) // RQ1
    else $error("execution length does not match machine cycles");
  a_pc_advance: assert property (dec_valid |-> pc == pc_start + {14'h0000, dec.info.len}) // RQ21
    else $error("program counter did not advance by instruction length");
  a_and_imm_dir: assert property (dec_valid && dec.opcode == {`LMD_HI_AND, `LMD_LO_DIR_IMM} // RQ1
      |-> dec.info.op == OP_AND && dec.info.len == `LMD_LEN3 && dec.info.cyc == `LMD_CYC2)
    else $error("and immediate to direct decoded wrongly");
  a_or_reg_form: assert property (dec_valid && dec.opcode[7:4] == `LMD_HI_OR && dec.opcode[3] // RQ2
      |-> dec.info.op == OP_OR && dec.info.src == M_REG && dec.info.cyc == `LMD_CYC1)
    else $error("or register form decoded wrongly");
  a_xor_imm_dir: assert property (dec_valid && dec.opcode == {`LMD_HI_XOR, `LMD_LO_DIR_IMM} // RQ3
      |-> dec.info.op == OP_XOR && dec.info.len == `LMD_LEN3 && dec.info.dst == M_DIR)
    else $error("xor immediate to direct decoded wrongly");
  a_reg_select: assert property (dec_valid && dec.info.src == M_REG // RQ19
      |-> dec.reg_addr == {$past(bank_sel), dec.opcode[2:0]})
    else $error("working register index wrong");
  a_ind_select: assert property (dec_valid && dec.info.src == M_IND // RQ20
      |-> dec.reg_addr[2:0] == {2'h0, dec.opcode[0]})
    else $error("indirect pointer register wrong");
  a_data_pointer_load: assert property (dec_valid && dec.opcode == `LMD_OPC_DATA_POINTER // RQ12
      |-> data_pointer == {dec.opnd1, dec.opnd2})
    else $error("data pointer not loaded from operands");
  a_table_pc: assert property (dec_valid && dec.opcode == `LMD_OPC_TBL_PC // RQ13
      |-> table_addr == pc + {8'h00, $past(acc_value)})
    else $error("pc relative table address wrong");
  a_mov_reg_dir: assert property (dec_valid && dec.opcode[7:4] == `LMD_HI_MOVR_DIR && dec.opcode[3] // RQ8
      |-> busy [*2] ##1 busy)
    else $error("move direct to register ends too early");
  a_fetch_order: assert property (code_rd |-> !busy && state == ST_WAIT) // RQ21
    else $error("fetch issued during execution");
  a_misuse_flag: assert property (misuse_flag |-> dec_valid && dec.opcode == `LMD_OPC_MOVA_D) // RQ7
    else $error("misuse flag without direct load of accumulator");

  c_three_byte: cover property (dec_valid && dec.info.len == `LMD_LEN3);
  c_table_read: cover property (dec_valid && dec.info.op == OP_CODE_TABLE ##[1:40] exec_done);
  c_low_nibble_exchange_op: cover property (dec_valid && dec.info.op == OP_LOW_NIBBLE_EXCHANGE_OP);
  c_misuse: cover property (misuse_flag);
endmodule

/* test/lmd_code_mem.sv */
// Program memory model answering the decoder's instruction fetches
`timescale 1ns/1ps
module lmd_code_mem (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        code_rd,
  input  wire logic [15:0] code_addr,
  input  wire logic [1:0]  mem_lat,
  output logic             code_ack,
  output logic      [7:0]  code_data
);
  logic [7:0] mem [0:1023];
  int         wait_n;
  // ----
  // Loading by the bench
  // ----
  task automatic put(input logic [9:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
  // ----
  // Fetch answer, after the bench's drive delay
  // ----
  initial begin
    code_ack = 1'b0;
    code_data = 8'h00;
    forever begin
      @(posedge sys_clk);
      #2;
      if (rst_n === 1'b1 && code_rd === 1'b1) begin
        wait_n = int'(mem_lat);
        while (wait_n > 0 && rst_n === 1'b1) begin
          wait_n--;
          @(posedge sys_clk);
          #2;
        end
        if (rst_n === 1'b1) begin
          code_ack = 1'b1;
          code_data = mem[code_addr[9:0]];
          @(posedge sys_clk);
          #2;
          code_ack = 1'b0;
          // Stale byte inverted so it never passes for a fresh one
          code_data = ~code_data;
        end
      end
    end
  end
endmodule

/* test/logic_and_move_insn_decode_bench.sv */
// Self-checking bench for the logic and move decoder
`timescale 1ns/1ps
module logic_and_move_insn_decode_bench;
  import lmd_pkg::*;
  // Short machine cycle keeps the run small
  localparam int MC = 2;
  localparam int LIMIT = 60000;
  typedef struct packed {
    logic [7:0]  opc, b1, b2;
    logic [8:0]  t;
    logic [4:0]  ra;
    logic [15:0] pc, tbl, dp;
    logic        mis, ind;
  } lmd_exp_s;
  logic        sys_clk, rst_n, code_ack, code_rd, dec_valid, busy, exec_done;
  logic        misuse_flag, unknown_flag, draining, checking;
  logic [1:0]  bank_sel, mem_lat;
  logic [7:0]  acc_value, code_data;
  logic [15:0] code_addr, pc, data_pointer, table_addr;
  lmd_dec_s    dec;
  int          miscompares, cmp_count, cycles;
  lmd_exp_s    q[$];
  lmd_decoder #(.MCYCLE_CLKS(MC)) i_lmd_decoder (
    .sys_clk(sys_clk), .rst_n(rst_n), .bank_sel(bank_sel), .acc_value(acc_value),
    .code_ack(code_ack), .code_data(code_data), .code_rd(code_rd), .code_addr(code_addr),
    .dec_valid(dec_valid), .dec(dec), .busy(busy), .exec_done(exec_done), .pc(pc),
    .data_pointer(data_pointer), .table_addr(table_addr), .misuse_flag(misuse_flag),
    .unknown_flag(unknown_flag));
  lmd_code_mem i_lmd_code_mem (
    .sys_clk(sys_clk), .rst_n(rst_n), .code_rd(code_rd), .code_addr(code_addr),
    .mem_lat(mem_lat), .code_ack(code_ack), .code_data(code_data));
  // ----
  // Checking and closing
  // ----
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: got %0h expected %0h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string msg);
    chk_val({15'h0000, got}, {15'h0000, exp}, msg);
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----
  // Reference table: class, then length and cycles two bits each
  // ----
  function automatic logic [8:0] ref_info(input logic [7:0] o);
    logic [8:0] t;
    lmd_op_e    lg;
    t = {OP_OTHER, 4'h5};
    lg = (o[7:4] == 4'h5) ? OP_AND : (o[7:4] == 4'h4) ? OP_OR : OP_XOR;
    if (o[7:4] inside {4'h4, 4'h5, 4'h6}) begin
      casez (o[3:0])
        4'b1???, 4'h6, 4'h7: t = {lg, 4'h5};
        4'h2, 4'h4, 4'h5: t = {lg, 4'h9};
        4'h3: t = {lg, 4'hE};
        default: t = {OP_OTHER, 4'h5};
      endcase
    end else begin
      casez (o)
        8'hE4: t = {OP_CLEAR, 4'h5};
        8'hF4: t = {OP_INVERT, 4'h5};
        8'hC4: t = {OP_SWAP, 4'h5};
        8'h23: t = {OP_ROT_L, 4'h5};
        8'h33: t = {OP_ROT_LC, 4'h5};
        8'h03: t = {OP_ROT_R, 4'h5};
        8'h13: t = {OP_ROT_RC, 4'h5};
        8'b1110_1???, 8'hE6, 8'hE7, 8'b1111_1???, 8'hF6, 8'hF7: t = {OP_MOVE, 4'h5};
        8'hE5, 8'h74, 8'b0111_1???, 8'hF5, 8'h76, 8'h77: t = {OP_MOVE, 4'h9};
        8'b1010_1???, 8'b1000_1???, 8'h86, 8'h87, 8'hA6, 8'hA7: t = {OP_MOVE, 4'hA};
        8'h85, 8'h75: t = {OP_MOVE, 4'hE};
        8'h90: t = {OP_DATA_POINTER_LOAD, 4'hE};
        8'h93, 8'h83: t = {OP_CODE_TABLE, 4'h6};
        8'hE0, 8'hE2, 8'hE3: t = {OP_EXT_READ, 4'h6};
        8'hF0, 8'hF2, 8'hF3: t = {OP_EXT_WRITE, 4'h6};
        8'hC0: t = {OP_PUSH, 4'hA};
        8'hD0: t = {OP_POP, 4'hA};
        8'b1100_1???, 8'hC6, 8'hC7: t = {OP_XCH, 4'h5};
        8'hC5: t = {OP_XCH, 4'h9};
        8'hD6, 8'hD7: t = {OP_LOW_NIBBLE_EXCHANGE_OP, 4'h5};
        default: t = {OP_OTHER, 4'h5};
      endcase
    end
    return t;
  endfunction
  // ----
  // Driver: one reset, then every opcode once in a shuffled order
  // ----
  task automatic run_seg(input int seg);
    logic [15:0] a, dp;
    logic [7:0]  xm, o;
    lmd_exp_s    e;
    int          n;
    a = 16'h0000;
    dp = 16'h0000;
    xm = 8'($urandom);
    rst_n = 1'b0;
    draining = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
    chk_flag(code_rd | dec_valid | busy, 1'b0, "active in reset");
    chk_val(pc, 16'h0000, "pc in reset");
    bank_sel = 2'($urandom);
    acc_value = 8'($urandom);
    mem_lat = 2'(seg % 3);
    for (int i = 0; i < 256; i++) begin
      o = 8'(i) ^ xm;
      e.opc = o;
      e.b1 = 8'($urandom);
      e.b2 = 8'($urandom);
      if (o == 8'hE5 && seg == 0) e.b1 = 8'hE0;
      else if (o == 8'hE5 && e.b1 == 8'hE0) e.b1 = 8'hE1;
      e.t = ref_info(o);
      e.ind = (e.t[8:4] != 5'h00) && (o[3:1] == 3'b011 || o inside {8'hE2, 8'hE3, 8'hF2, 8'hF3});
      e.ra = e.ind ? {bank_sel, 2'b00, o[0]} : {bank_sel, o[2:0]};
      e.mis = (o == 8'hE5) && (e.b1 == 8'hE0);
      i_lmd_code_mem.put(a[9:0], o);
      i_lmd_code_mem.put(10'(a + 16'h0001), e.b1);
      i_lmd_code_mem.put(10'(a + 16'h0002), e.b2);
      e.tbl = 16'(acc_value) + ((o == 8'h93) ? dp : a + 16'(e.t[3:2]));
      a = a + 16'(e.t[3:2]);
      e.pc = a;
      if (o == 8'h90) dp = {e.b1, e.b2};
      e.dp = dp;
      q.push_back(e);
    end
    draining = 1'b0;
    rst_n = 1'b1;
    n = 0;
    while ((q.size() != 0 || checking) && n < 20000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    // A stalled segment must not slip through to a clean verdict
    if (q.size() != 0 || checking) miscompares++;
  endtask
  // ----
  // Watcher: compares each decode with the oldest note
  // ----
  initial begin
    lmd_exp_s e;
    int       n;
    forever begin
      @(posedge sys_clk);
      #1;
      if (dec_valid === 1'b1 && q.size() == 0 && !draining) begin
        chk_flag(1'b1, 1'b0, "decode with nothing expected");
      end else if (dec_valid === 1'b1 && q.size() != 0) begin
        checking = 1'b1;
        e = q.pop_front();
        chk_val(dec.opcode, e.opc, "opcode");
        chk_val(dec.info.op, e.t[8:4], "class");
        chk_val(dec.info.len, e.t[3:2], "length");
        chk_val(dec.info.cyc, e.t[1:0], "cycles");
        chk_flag(unknown_flag, e.t[8:4] == 5'h00, "unknown flag");
        chk_flag(dec.info.known, e.t[8:4] != 5'h00, "known");
        chk_flag(dec.info.src == M_IND || dec.info.dst == M_IND, e.ind, "indirect mode");
        chk_flag(misuse_flag, e.mis, "misuse flag");
        chk_val(pc, e.pc, "pc");
        chk_val(data_pointer, e.dp, "data pointer");
        if (e.t[8:4] != 5'h00) chk_val(dec.reg_addr, e.ra, "reg addr");
        if (e.t[3:2] >= 2'h2) chk_val(dec.opnd1, e.b1, "byte two");
        if (e.t[3:2] == 2'h3) chk_val(dec.opnd2, e.b2, "byte three");
        if (e.opc inside {8'h93, 8'h83}) chk_val(table_addr, e.tbl, "table addr");
        n = 0;
        while (busy === 1'b1 && n < 64) begin
          n++;
          @(posedge sys_clk);
          #1;
        end
        chk_val(16'(n), 16'(e.t[1:0]) * 16'(MC), "busy length");
        chk_flag(exec_done, 1'b1, "exec done");
        checking = 1'b0;
      end
    end
  end
  // ----
  // Clock, hang limit and main sequence
  // ----
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    rst_n = 1'b0;
    bank_sel = 2'b00;
    acc_value = 8'h00;
    mem_lat = 2'b00;
    draining = 1'b1;
    checking = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    void'($urandom(32'hCB79687D));
    #1;
    for (int s = 0; s < 4; s++) begin
      run_seg(s);
    end
    tally_and_finish();
  end
endmodule
